// ---- core/sdm_top.sv ----
// Safe direction monitor: release, overrides, indicators and registers.
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "sdm_map.svh"

// What this block does
// - Opposite motion past tolerance drops release.
// - Direction code 1 right, 2 left.
// - Tolerance unit codes ms, s, min, h.
// - Deviation within tolerance keeps release.
// - Manual mode waits for restart pulse.
// - Restart code 1 manual, 2 automatic.
// - Enabled mute holds an existing release.
// - Enabled bypass forces release high.
// - Reset pulse clears error; reset-required shows.
// - Restart-required while waiting for acknowledge.
// - Right and left movement outputs.
// - Release high only when conditions met.
// - Mute and bypass enables, default off.
// - Time limit ends mute and bypass.
// - Reset/restart pulses need debounce time.
// - Steady or flashing required outputs.
// - Fault flag enable gates error outputs.
// - General plus five sensor fault outputs.
module sdm_top #(
    parameter int MS_CYCLES = `SDM_MS_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [31:0] rdata,
    input  wire logic        enc_a,
    input  wire logic        enc_b,
    input  wire logic        restart_in,
    input  wire logic        reset_in,
    input  wire logic        mute_in,
    input  wire logic        bypass_in,
    input  wire logic [4:0]  sensor_fault,
    output logic             release_out,
    output logic             right_move,
    output logic             left_move,
    output logic             restart_required,
    output logic             reset_required,
    output logic      [5:0]  fault_flags
);
    import sdm_pkg::*;

    // ********************************
    // Parameter check
    // ********************************
    initial begin
        if (MS_CYCLES < 1 || MS_CYCLES > 65536) begin
            $error("MS_CYCLES must lie between 1 and 65536");
        end
    end

    typedef struct packed {
        sdm_state_type state;
        logic [15:0]   ms_div;
        logic [1:0]    dir;
        logic [2:0]    unit;
        logic [1:0]    restart_mode;
        logic          mute_en;
        logic          bypass_en;
        logic          limit_en;
        logic [1:0]    deb_sel;
        logic          flash;
        logic          fflag_en;
        logic [13:0]   tol;
        logic [12:0]   limit;
        logic [21:0]   tol_ms;
        logic [13:0]   tol_cnt;
        logic [9:0]    ov_ms;
        logic [12:0]   ov_sec;
        logic          ov_expired;
        logic [8:0]    flash_ms;
        logic          blink;
        logic [31:0]   rdata;
        logic          release_q;
        logic          right;
        logic          left;
        logic          restart_req;
        logic          reset_req;
        logic [5:0]    fault_flags;
    } sdm_top_type;

    sdm_top_type  r;
    sdm_top_type  next_r;
    sdm_motion_if mif ();

    logic         ms_tick;
    logic         restart_ok;
    logic         reset_ok;
    logic [8:0]   deb_ms;

    // ********************************
    // Motion decoding and pulse qualification
    // ********************************
    sdm_quad_decode u_decode (
        .clk   (clk),
        .reset (reset),
        .enc_a (enc_a),
        .enc_b (enc_b),
        .mif   (mif.decoder)
    );

    sdm_debounce u_restart_deb (
        .clk     (clk),
        .reset   (reset),
        .ms_tick (ms_tick),
        .min_ms  (deb_ms),
        .level   (restart_in),
        .pulse   (restart_ok)
    );

    sdm_debounce u_reset_deb (
        .clk     (clk),
        .reset   (reset),
        .ms_tick (ms_tick),
        .min_ms  (deb_ms),
        .level   (reset_in),
        .pulse   (reset_ok)
    );

    assign ms_tick = (r.ms_div == 16'(MS_CYCLES - 1));
    assign mif.ms_tick = ms_tick;

    // ********************************
    // Next state
    // ********************************
    always_comb begin
        logic [21:0] unit_ms;
        logic        wrong;
        logic        violation;
        logic        error;
        logic        mute_act;
        logic        byp_act;
        logic        show;
        logic [13:0] tol_w;
        logic [12:0] lim_w;
        next_r = r;
        unit_ms = `SDM_MS_PER_SEC;
        wrong = 1'b0;
        violation = 1'b0;
        error = |sensor_fault;
        mute_act = 1'b0;
        byp_act = 1'b0;
        show = 1'b0;
        tol_w = wdata[13:0];
        lim_w = wdata[12:0];

        next_r.ms_div = ms_tick ? 16'h0000 : r.ms_div + 16'h0001;

        // Register writes; tolerance and limit are clamped to range.
        if (wr_en) begin
            unique case (addr)
                `SDM_ADDR_CFG: begin
                    next_r.dir = wdata[`SDM_CFG_DIR_LSB +: 2];
                    next_r.unit = wdata[`SDM_CFG_UNIT_LSB +: 3];
                    next_r.restart_mode = wdata[`SDM_CFG_RST_LSB +: 2];
                    next_r.mute_en = wdata[`SDM_CFG_MUTE_BIT];
                    next_r.bypass_en = wdata[`SDM_CFG_BYP_BIT];
                    next_r.limit_en = wdata[`SDM_CFG_LIMEN_BIT];
                    next_r.deb_sel = wdata[`SDM_CFG_DEB_LSB +: 2];
                    next_r.flash = wdata[`SDM_CFG_FLASH_BIT];
                    next_r.fflag_en = wdata[`SDM_CFG_FFLAG_BIT];
                end
                `SDM_ADDR_TOL: begin
                    next_r.tol = (tol_w > `SDM_TOL_MAX) ?
                        `SDM_TOL_MAX : tol_w;
                end
                `SDM_ADDR_LIMIT: begin
                    if (lim_w < `SDM_LIMIT_MIN) begin
                        next_r.limit = `SDM_LIMIT_MIN;
                    end else if (lim_w > `SDM_LIMIT_MAX) begin
                        next_r.limit = `SDM_LIMIT_MAX;
                    end else begin
                        next_r.limit = lim_w;
                    end
                end
                default: begin
                end
            endcase
        end

        // Tolerance timebase; unknown unit codes fall back to seconds.
        unique case (r.unit)
            `SDM_UNIT_MS:   unit_ms = 22'h000001;
            `SDM_UNIT_MIN:  unit_ms = `SDM_MS_PER_MIN;
            `SDM_UNIT_HOUR: unit_ms = `SDM_MS_PER_HOUR;
            default:        unit_ms = `SDM_MS_PER_SEC;
        endcase

        // Any code other than left selects right.
        wrong = (r.dir == `SDM_DIR_LEFT) ? mif.right : mif.left;
        if (!wrong) begin
            next_r.tol_ms = 22'h000000;
            next_r.tol_cnt = 14'h0000;
        end else if (ms_tick) begin
            if (r.tol_ms + 22'h000001 >= unit_ms) begin
                next_r.tol_ms = 22'h000000;
                if (r.tol_cnt != 14'h3FFF) begin
                    next_r.tol_cnt = r.tol_cnt + 14'h0001;
                end
            end else begin
                next_r.tol_ms = r.tol_ms + 22'h000001;
            end
        end
        // A tolerance of zero trips on the first wrong-way cycle.
        violation = wrong && (r.tol_cnt >= r.tol);

        // Release sequencing. A sensor fault always wins.
        if (error) begin
            next_r.state = S_FAULT;
        end else begin
            unique case (r.state)
                S_IDLE: begin
                    if (!violation) begin
                        next_r.state =
                            (r.restart_mode == `SDM_RESTART_MANUAL) ?
                            S_WAIT_RESTART : S_RELEASE;
                    end
                end
                S_WAIT_RESTART: begin
                    if (violation) begin
                        next_r.state = S_IDLE;
                    end else if (restart_ok) begin
                        next_r.state = S_RELEASE;
                    end
                end
                S_RELEASE: begin
                    if (violation) begin
                        next_r.state = S_IDLE;
                    end
                end
                S_FAULT: begin
                    if (reset_ok) begin
                        next_r.state = S_IDLE;
                    end
                end
            endcase
        end

        // Mute and bypass share one time limit, restarted only after
        // both enabled inputs have fallen, so holding them cannot re-arm it.
        mute_act = r.mute_en && mute_in;
        byp_act = r.bypass_en && bypass_in;
        if (!(mute_act || byp_act)) begin
            next_r.ov_ms = 10'h000;
            next_r.ov_sec = 13'h0000;
            next_r.ov_expired = 1'b0;
        end else if (r.limit_en && !r.ov_expired && ms_tick) begin
            if (r.ov_ms == 10'h3E7) begin
                next_r.ov_ms = 10'h000;
                next_r.ov_sec = r.ov_sec + 13'h0001;
                if (r.ov_sec + 13'h0001 >= r.limit) begin
                    next_r.ov_expired = 1'b1;
                end
            end else begin
                next_r.ov_ms = r.ov_ms + 10'h001;
            end
        end

        next_r.release_q =
            (r.state == S_RELEASE && !violation && !error) ||
            (mute_act && !r.ov_expired && r.release_q) ||
            (byp_act && !r.ov_expired);

        // Indicator flashing.
        if (ms_tick) begin
            if (r.flash_ms >= `SDM_FLASH_MS - 9'h001) begin
                next_r.flash_ms = 9'h000;
                next_r.blink = !r.blink;
            end else begin
                next_r.flash_ms = r.flash_ms + 9'h001;
            end
        end
        show = !r.flash || r.blink;
        next_r.restart_req = (r.state == S_WAIT_RESTART) && show;
        next_r.reset_req = (r.state == S_FAULT) && !error && show;

        next_r.right = mif.right;
        next_r.left = mif.left;
        next_r.fault_flags = r.fflag_en ?
            {sensor_fault, error} : 6'h00;

        next_r.rdata = 32'h00000000;
        if (rd_en) begin
            unique case (addr)
                `SDM_ADDR_CFG: begin
                    next_r.rdata = {18'h00000, r.fflag_en, r.flash,
                        r.deb_sel, r.limit_en, r.bypass_en, r.mute_en,
                        r.restart_mode, r.unit, r.dir};
                end
                `SDM_ADDR_TOL:   next_r.rdata = {18'h00000, r.tol};
                `SDM_ADDR_LIMIT: next_r.rdata = {19'h00000, r.limit};
                `SDM_ADDR_STATUS: begin
                    next_r.rdata = {17'h00000, r.fault_flags,
                        r.ov_expired, violation, r.state,
                        r.reset_req, r.restart_req, r.left,
                        r.right, r.release_q};
                end
                default: begin
                end
            endcase
        end
    end

    // ********************************
    // Debounce time select
    // ********************************
    always_comb begin
        unique case (r.deb_sel)
            `SDM_DEB_100: deb_ms = `SDM_DEB100_MS;
            `SDM_DEB_350: deb_ms = `SDM_DEB350_MS;
            default:      deb_ms = 9'h000;
        endcase
    end

    // ********************************
    // State register
    // ********************************
    always_ff @(posedge clk) begin
        if (reset) begin
            r <= '0;
            r.state <= S_IDLE;
            r.dir <= `SDM_RST_DIR;
            r.unit <= `SDM_RST_UNIT;
            r.restart_mode <= `SDM_RST_RESTART;
            r.limit_en <= `SDM_RST_LIMEN;
            r.deb_sel <= `SDM_RST_DEB;
            r.tol <= `SDM_RST_TOL;
            r.limit <= `SDM_RST_LIMIT;
        end else begin
            r <= next_r;
        end
    end

    assign rdata = r.rdata;
    assign release_out = r.release_q;
    assign right_move = r.right;
    assign left_move = r.left;
    assign restart_required = r.restart_req;
    assign reset_required = r.reset_req;
    assign fault_flags = r.fault_flags;
endmodule

// ---- core/sdm_map.svh ----
// Register offsets, field positions, reset values and timing counts.
`ifndef SDM_MAP_SVH
`define SDM_MAP_SVH
`define SDM_ADDR_CFG       8'h00
`define SDM_ADDR_TOL       8'h04
`define SDM_ADDR_LIMIT     8'h08
`define SDM_ADDR_STATUS    8'h0C
`define SDM_CFG_DIR_LSB    0
`define SDM_CFG_UNIT_LSB   2
`define SDM_CFG_RST_LSB    5
`define SDM_CFG_MUTE_BIT   7
`define SDM_CFG_BYP_BIT    8
`define SDM_CFG_LIMEN_BIT  9
`define SDM_CFG_DEB_LSB    10
`define SDM_CFG_FLASH_BIT  12
`define SDM_CFG_FFLAG_BIT  13
`define SDM_RST_DIR        2'h1
`define SDM_RST_UNIT       3'h2
`define SDM_RST_RESTART    2'h2
`define SDM_RST_LIMEN      1'h1
`define SDM_RST_DEB        2'h1
`define SDM_RST_TOL        14'h0000
`define SDM_RST_LIMIT      13'h0001
`define SDM_DIR_LEFT       2'h2
`define SDM_UNIT_MS        3'h1
`define SDM_UNIT_MIN       3'h3
`define SDM_UNIT_HOUR      3'h4
`define SDM_RESTART_MANUAL 2'h1
`define SDM_DEB_100        2'h1
`define SDM_DEB_350        2'h2
`define SDM_TOL_MAX        14'h2710
`define SDM_LIMIT_MIN      13'h0001
`define SDM_LIMIT_MAX      13'h1C20
`define SDM_MS_PER_SEC     22'h0003E8
`define SDM_MS_PER_MIN     22'h00EA60
`define SDM_MS_PER_HOUR    22'h36EE80
`define SDM_DEB100_MS      9'h064
`define SDM_DEB350_MS      9'h15E
`define SDM_FLASH_MS       9'h0FA
`define SDM_STILL_MS       8'h32
`define SDM_CLK_PERIOD_NS  100
`define SDM_MS_NS          1000000
`define SDM_MS_CYCLES      (`SDM_MS_NS / `SDM_CLK_PERIOD_NS)
`define SDM_FLT_GENERAL    0
`endif

// ---- core/sdm_pkg.sv ----
// Types shared by the direction monitor modules.
package sdm_pkg;
    typedef enum logic [1:0] {
        S_IDLE,
        S_WAIT_RESTART,
        S_RELEASE,
        S_FAULT
    } sdm_state_type;

    typedef struct packed {
        logic       armed;
        logic       prev;
        logic [8:0] high_ms;
        logic       pulse;
    } sdm_deb_type;

    typedef struct packed {
        logic       seeded;
        logic [1:0] ab_prev;
        logic       right;
        logic       left;
        logic [7:0] still_ms;
    } sdm_quad_type;
endpackage

// ---- core/sdm_motion_if.sv ----
// Millisecond tick and decoded motion between decoder and monitor.
`timescale 1ns/1ps
interface sdm_motion_if;
    logic ms_tick;
    logic right;
    logic left;
    modport decoder (input ms_tick, output right, output left);
    modport monitor (output ms_tick, input right, input left);
endinterface

// ---- core/sdm_debounce.sv ----
// Low-high-low pulse qualifier with a minimum high time in milliseconds.
`timescale 1ns/1ps
module sdm_debounce (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       ms_tick,
    input  wire logic [8:0] min_ms,
    input  wire logic       level,
    output logic            pulse
);
    import sdm_pkg::*;
    sdm_deb_type r;
    sdm_deb_type next_r;

    // The high time is counted in whole milliseconds, so an accepted
    // pulse may be up to one millisecond shorter than min_ms.
    always_comb begin
        next_r = r;
        next_r.prev = level;
        next_r.pulse = 1'b0;
        if (!level) begin
            next_r.pulse = r.prev && r.armed && (r.high_ms >= min_ms);
            next_r.armed = 1'b1;
            next_r.high_ms = 9'h000;
        end else if (ms_tick && r.high_ms != 9'h1FF) begin
            next_r.high_ms = r.high_ms + 9'h001;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign pulse = r.pulse;
endmodule

// ---- core/sdm_quad_decode.sv ----
// Quadrature decoder that reports the current direction of motion.
`timescale 1ns/1ps
module sdm_quad_decode (
    input  wire logic     clk,
    input  wire logic     reset,
    input  wire logic     enc_a,
    input  wire logic     enc_b,
    sdm_motion_if.decoder mif
);
    import sdm_pkg::*;
    sdm_quad_type r;
    sdm_quad_type next_r;
    logic         step;
    logic         fwd;

    always_comb begin
        next_r = r;
        next_r.seeded = 1'b1;
        next_r.ab_prev = {enc_a, enc_b};
        // A double change is a missed edge and gives no direction.
        step = r.seeded && ((enc_a ^ r.ab_prev[1]) != (enc_b ^ r.ab_prev[0]));
        fwd = r.ab_prev[1] ^ enc_b;
        if (step) begin
            next_r.right = fwd;
            next_r.left = !fwd;
            next_r.still_ms = 8'h00;
        end else if (mif.ms_tick) begin
            if (r.still_ms >= `SDM_STILL_MS - 8'h01) begin
                next_r.right = 1'b0;
                next_r.left = 1'b0;
            end else begin
                next_r.still_ms = r.still_ms + 8'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign mif.right = r.right;
    assign mif.left = r.left;
endmodule

// ---- verif/sdm_enc_model.sv ----
// Quadrature encoder model that steps while the bench commands motion.
`timescale 1ns/1ps
module sdm_enc_model (
    input  wire logic       clk,
    input  wire logic [1:0] run,
    output logic            enc_a,
    output logic            enc_b
);
    localparam int GAP = 8;
    logic [1:0] phase = 2'h0;
    int         cnt = 0;

    // A stopped encoder holds its levels.
    always @(posedge clk) begin
        cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
        if (cnt == 0 && run == 2'h1) phase <= phase + 2'h1;
        if (cnt == 0 && run == 2'h2) phase <= phase - 2'h1;
    end
    assign enc_a = phase[1];
    assign enc_b = phase[1] ^ phase[0];
endmodule

// ---- verif/sdm_top_chk.sv ----
// Concurrent checks on the direction monitor ports.
`timescale 1ns/1ps
`include "sdm_map.svh"
module sdm_top_chk #(
    parameter int MS_CYCLES = 10000
) (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr_en,
    input wire logic        mute_in,
    input wire logic        bypass_in,
    input wire logic [4:0]  sensor_fault,
    input wire logic        release_out,
    input wire logic        right_move,
    input wire logic        left_move,
    input wire logic        restart_required,
    input wire logic        reset_required,
    input wire logic [5:0]  fault_flags
);
    // Stay below the shortest limit so an expiry never looks like a slip while MS_CYCLES is at most 11.
    localparam int HOLD_MAX = 1000 * MS_CYCLES - 10;
    logic flags_en;
    logic mute_en;
    logic byp_en;
    logic quiet;
    int   ovr_run;

    always_ff @(posedge clk) begin
        if (reset) begin
            flags_en <= 1'b0;
            mute_en  <= 1'b0;
            byp_en   <= 1'b0;
            ovr_run  <= 0;
        end else begin
            if (wr_en && addr == `SDM_ADDR_CFG) begin
                flags_en <= wdata[`SDM_CFG_FFLAG_BIT];
                mute_en  <= wdata[`SDM_CFG_MUTE_BIT];
                byp_en   <= wdata[`SDM_CFG_BYP_BIT];
            end
            ovr_run <= (mute_in || bypass_in) ? ovr_run + 1 : 0;
        end
    end
    assign quiet = !mute_en && !byp_en;

    // ********************************
    // Properties
    // ********************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    property p_flags_off;
        !flags_en && !$past(flags_en) |-> fault_flags == 6'h00;
    endproperty
    a_flags_off: assert property (p_flags_off)
        else $error("fault flags active while disabled");
    property p_flags_map;
        flags_en && $past(flags_en) |-> fault_flags[5:1] ==
            $past(sensor_fault) && fault_flags[0] == |$past(sensor_fault);
    endproperty
    a_flags_map: assert property (p_flags_map)
        else $error("fault flags wrong");
    property p_dir_excl;
        !(right_move && left_move);
    endproperty
    a_dir_excl: assert property (p_dir_excl)
        else $error("right and left movement both high");
    property p_req_excl;
        !(reset_required && restart_required);
    endproperty
    a_req_excl: assert property (p_req_excl)
        else $error("reset and restart required together");
    property p_wait_dark;
        quiet && $past(quiet) && restart_required |-> !release_out;
    endproperty
    a_wait_dark: assert property (p_wait_dark)
        else $error("release while restart awaited");
    property p_fault_drop;
        quiet && |sensor_fault |-> ##2 !release_out;
    endproperty
    a_fault_drop: assert property (p_fault_drop)
        else $error("release kept on fault");
    property p_bypass;
        byp_en && $rose(bypass_in) && !$past(mute_in) |-> ##[1:3] release_out;
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("bypass did not force release");
    property p_mute;
        mute_en && mute_in && release_out && ovr_run < HOLD_MAX |=> release_out;
    endproperty
    a_mute: assert property (p_mute)
        else $error("mute did not hold release");

    c_release: cover property ($rose(release_out));
    c_bypass: cover property (byp_en && bypass_in && release_out);
    c_restart: cover property ($fell(restart_required) && release_out);
    c_reset_req: cover property ($rose(reset_required));
endmodule

bind sdm_top sdm_top_chk #(.MS_CYCLES(MS_CYCLES)) i_sdm_top_chk (
    .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .mute_in(mute_in), .bypass_in(bypass_in), .sensor_fault(sensor_fault),
    .release_out(release_out), .right_move(right_move),
    .left_move(left_move), .restart_required(restart_required),
    .reset_required(reset_required), .fault_flags(fault_flags)
);

// ---- verif/sdm_top_bench.sv ----
// Self-checking bench for the safe direction monitor.
`timescale 1ns/1ps
module sdm_top_bench;
    typedef struct {
        string       what;
        logic [31:0] mask;
        logic [31:0] exp;
    } sdm_note_type;
    localparam logic [31:0] CFG0 = 32'h0000_0249;
    localparam logic [31:0] REL = 32'h0000_0001;
    localparam logic [31:0] MOV = 32'h0000_0006;
    localparam logic [31:0] RSQ = 32'h0000_0008;
    localparam logic [31:0] RRQ = 32'h0000_0010;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic        rd_d = 1'b0;
    logic [1:0]  run = 2'h0;
    logic        restart_in = 1'b0;
    logic        reset_in = 1'b0;
    logic        mute_in = 1'b0;
    logic        bypass_in = 1'b0;
    logic [4:0]  sensor_fault = 5'h00;
    logic [4:0]  f;
    logic [31:0] rdata;
    logic        enc_a, enc_b, release_out, right_move, left_move;
    logic        restart_required, reset_required;
    logic [5:0]  fault_flags;
    int          bad_count = 0;
    int          check_count = 0;
    int          hi_seen, lo_seen;
    int          lo_len[3] = '{1, 500, 1700};
    int          hi_len[3] = '{1, 1100, 3600};
    sdm_note_type note_q[$];
    sdm_note_type n;

    sdm_top #(.MS_CYCLES(10)) i_sdm_top (
        .clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .enc_a(enc_a),
        .enc_b(enc_b), .restart_in(restart_in), .reset_in(reset_in),
        .mute_in(mute_in), .bypass_in(bypass_in),
        .sensor_fault(sensor_fault), .release_out(release_out),
        .right_move(right_move), .left_move(left_move),
        .restart_required(restart_required),
        .reset_required(reset_required), .fault_flags(fault_flags));
    sdm_enc_model i_sdm_enc_model (
        .clk(clk), .run(run), .enc_a(enc_a), .enc_b(enc_b));

    always #50 clk = ~clk;

    // ********************************
    // Shared tasks
    // ********************************
    task automatic check(input string w, input logic [31:0] s,
                         input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", w, e, s);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic wait_cyc(input int c);
        repeat (c) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input string w, input logic [7:0] a,
                      input logic [31:0] m, input logic [31:0] e);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        note_q.push_back('{w, m, e});
        @(posedge clk);
        rd_en <= 1'b0;
    endtask
    task automatic st(input logic [31:0] m, input logic [31:0] e);
        rd("status", 8'h0C, m, e);
    endtask
    task automatic wrong(input int c);
        run <= 2'h2;
        wait_cyc(c);
        run <= 2'h0;
    endtask
    task automatic pulse(input bit rst, input int hi);
        @(posedge clk);
        if (rst) reset_in <= 1'b1; else restart_in <= 1'b1;
        wait_cyc(hi);
        reset_in   <= 1'b0;
        restart_in <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe.
    always @(posedge clk) begin
        rd_d <= rd_en;
        if (rd_d && note_q.size() > 0) begin
            n = note_q.pop_front();
            check(n.what, rdata & n.mask, n.exp);
        end
    end

    initial begin
        wait_cyc(60000);
        bad_count++;
        give_verdict();
    end

    initial begin
        void'($urandom(86148));
        wait_cyc(6);
        reset <= 1'b0;
        wait_cyc(5);
        st(REL | 32'h60, REL | 32'h40);
        rd("cfg", 8'h00, 32'hFFFF_FFFF, 32'h649);
        rd("limit", 8'h08, 32'hFFFF_FFFF, 32'h1);
        rd("unmapped", 8'h10, 32'hFFFF_FFFF, 32'h0);
        for (int u = 1; u <= 4; u++) begin
            wr(8'h00, 32'h241 | 32'(u << 2));
            rd("unit", 8'h00, 32'h1C, 32'(u << 2));
        end
        wr(8'h00, CFG0);
        run <= 2'h1;
        wait_cyc(40);
        st(REL | MOV, REL | 32'h2);
        wrong(40);
        st(REL | MOV, 32'h4);
        wr(8'h00, CFG0 + 32'h1);
        wait_cyc(20);
        st(REL, REL);
        wait_cyc(600);
        st(MOV, 32'h0);
        $display("test direction done");
        wr(8'h00, CFG0 - 32'h4);
        wr(8'h04, 32'h64);
        wrong(8);
        wait_cyc(700);
        st(REL, REL);
        wrong(1300);
        st(REL, 32'h0);
        wr(8'h04, 32'h0);
        wait_cyc(600);
        $display("test tolerance done");
        for (int d = 0; d < 3; d++) begin
            wr(8'h00, 32'h229 | 32'(d << 10));
            wrong(40);
            wait_cyc(600);
            st(REL | RSQ | 32'h60, RSQ | 32'h20);
            if (d > 0) pulse(1'b0, lo_len[d]);
            wait_cyc(10);
            st(REL, 32'h0);
            pulse(1'b0, hi_len[d]);
            wait_cyc(10);
            st(REL | RSQ, REL);
        end
        $display("test restart done");
        wr(8'h00, CFG0 | 32'h2000);
        f = 5'(1 << $urandom_range(4, 0));
        sensor_fault <= f;
        wait_cyc(5);
        check("flags", 32'(fault_flags), 32'({f, 1'b1}));
        st(REL | 32'h60, 32'h60);
        sensor_fault <= 5'h00;
        wait_cyc(5);
        st(REL | RRQ, RRQ);
        pulse(1'b1, 1);
        wait_cyc(10);
        st(REL | RRQ, REL);
        $display("test fault done");
        wr(8'h00, CFG0);
        run <= 2'h2;
        bypass_in <= 1'b1;
        wait_cyc(20);
        st(REL, 32'h0);
        bypass_in <= 1'b0;
        wr(8'h00, CFG0 | 32'h100);
        bypass_in <= 1'b1;
        wait_cyc(20);
        st(REL, REL);
        wait_cyc(10050);
        st(REL, 32'h0);
        bypass_in <= 1'b0;
        run <= 2'h0;
        wait_cyc(600);
        wr(8'h00, CFG0 | 32'h80);
        mute_in <= 1'b1;
        wrong(60);
        st(REL, REL);
        mute_in <= 1'b0;
        wait_cyc(10);
        st(REL, 32'h0);
        wait_cyc(600);
        $display("test overrides done");
        wr(8'h00, 32'h1229);
        wrong(40);
        hi_seen = 0;
        lo_seen = 0;
        repeat (6000) begin
            @(posedge clk);
            if (restart_required === 1'b1) hi_seen++;
            if (hi_seen > 0 && restart_required === 1'b0) lo_seen++;
        end
        check("flash", 32'(hi_seen > 0 && lo_seen > 0), 32'h1);
        $display("test flash done");
        wait_cyc(3);
        give_verdict();
    end
endmodule
